// ### core/hup_pkg.sv
// Purpose: constants and types shared by the host serial port with boot straps
// Assumes: 100 MHz core clock
// Notes: all framing and strap values live here
// Contract
// - boot strap high normal, low factory
// - printout strap high enables boot banner
// - printout pin becomes serial slave select
// - flash voltage pin becomes slave data out
// - receive on input, transmit on output
// - clear-to-send gates tx, request-to-send gates host
// - four wire or two wire operation
// - reset default 115200 8N1 flow control
// - dsr steers module state, dtr pin follows dtrLevel
// - dsr edge does configured action
// - firmware images arrive over same port
// - serial slave takes clock and select
package hup_pkg;
   localparam int unsigned CLK_HZ = 100_000_000; // core clock rate
   localparam int unsigned BAUD_DEFAULT = 115_200; // power-on baud rate
   localparam int unsigned BAUD_DIV = CLK_HZ / BAUD_DEFAULT; // cycles per bit
   localparam int unsigned DATA_BITS = 8; // default character length
   localparam int unsigned STOP_BITS = 1; // default stop bits
   localparam logic FLOW_DEFAULT = 1'b1; // flow control on after reset
   localparam logic STRAP_BOOT_NORMAL = 1'b1; // pulled-up boot strap value
   localparam logic STRAP_PRINT_ON = 1'b1; // pulled-up printout strap value
   localparam logic STRAP_FLASH_18V = 1'b1; // required flash strap value
   localparam int unsigned BANNER_LEN = 4; // bytes of boot banner
   localparam int unsigned STRAP_SYNC_CYCLES = 2; // strap levels settle through two flops first
   localparam logic [7:0] BANNER_BYTE0 = 8'h42; // banner content, arbitrary
   // dsr action encodings
   typedef enum logic [1:0] {
      HUP_DSR_CMD,
      HUP_DSR_DISC,
      HUP_DSR_UART_EN,
      HUP_DSR_STOP
   } hup_dsr_act_t;
endpackage : hup_pkg

// ### core/hup_tx_if.sv
// Purpose: byte handshake between port control and serial transmitter
// Assumes: single core clock
// Notes: valid held until ready
`timescale 1ns/1ps
`default_nettype none
interface hup_tx_if;
   logic valid; // byte offered
   logic ready; // transmitter takes it
   logic [7:0] data; // byte to send
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : hup_tx_if
`default_nettype wire

// ### core/hup_uart_tx.sv
// Purpose: serial transmitter, 8N1 framing, clear-to-send gating
// Assumes: ctsOk already synchronised
// Notes: a character in flight completes even if cts drops
`timescale 1ns/1ps
`default_nettype none
module hup_uart_tx
   import hup_pkg::*;
#(
   parameter int unsigned DIV = hup_pkg::BAUD_DIV
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ctsOk,
   hup_tx_if.snk tx,
   output logic txd,
   output logic busy
);
   typedef struct packed {
      logic act;
      logic [9:0] sh;
      logic [3:0] nb;
      logic [15:0] cnt;
   } hup_txs_t;
   hup_txs_t s_q, s_d;
   assign tx.ready = !s_q.act && ctsOk;
   assign txd = s_q.sh[0];
   assign busy = s_q.act;
   // next state: load a frame, then shift one bit each divider period
   always_comb begin
      s_d = s_q;
      if (!s_q.act) begin
         if (tx.valid && ctsOk) begin
            s_d.act = 1'b1;
            s_d.sh = {1'b1, tx.data, 1'b0};
            s_d.nb = 4'(DATA_BITS + STOP_BITS + 1);
            s_d.cnt = 16'(DIV - 1);
         end
      end else if (s_q.cnt == 16'h0000) begin
         s_d.cnt = 16'(DIV - 1);
         s_d.sh = {1'b1, s_q.sh[9:1]};
         s_d.nb = s_q.nb - 4'h1;
         if (s_q.nb == 4'h1) begin
            s_d.act = 1'b0;
         end
      end else begin
         s_d.cnt = s_q.cnt - 16'h0001;
      end
   end
   // state register, line idles high
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_q <= '{act: 1'b0, sh: 10'h3FF, nb: 4'h0, cnt: 16'h0000};
      end else begin
         s_q <= s_d;
      end
   end
   a_ready_gated: assert property (@(posedge core_clk) disable iff (rst)
      !ctsOk |-> !tx.ready) else $error("ready while cts blocked");
   a_start_bit: assert property (@(posedge core_clk) disable iff (rst)
      (tx.valid && tx.ready) |=> (!txd && busy)) else $error("no start bit");
endmodule : hup_uart_tx
`default_nettype wire

// ### core/hup_port.sv
// Purpose: host serial port with boot strap capture and pin reuse
// Assumes: pins arrive asynchronous and are synchronised here
// Notes: straps sampled once after reset release
`timescale 1ns/1ps
`default_nettype none
module hup_port
   import hup_pkg::*;
#(
   parameter int unsigned DIV = hup_pkg::BAUD_DIV,
   parameter int unsigned BANNER = hup_pkg::BANNER_LEN
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic rxdPin,
   input wire logic ctsPin,
   input wire logic dsrPin,
   input wire logic bootStrapPin,
   input wire logic printStrapPin,
   input wire logic flashStrapPin,
   input wire logic slaveClkPin,
   input wire logic [7:0] slaveTxByte,
   input wire logic twoWire,
   input wire hup_dsr_act_t dsrAction,
   input wire logic dtrLevel,
   input wire logic [7:0] hostTxData,
   input wire logic hostTxValid,
   output logic hostTxReady,
   output logic txd,
   output logic rtsPinN,
   output logic dtrPin,
   output logic [7:0] rxData,
   output logic rxValid,
   output logic factoryBoot,
   output logic flashIs18v,
   output logic bootDone,
   output logic cmdMode,
   output logic connectable,
   output logic uartEnabled,
   output logic stopMode,
   output logic fwImageByte,
   output logic slaveSelect,
   output logic misoOut,
   output logic misoOe
);
   // boot phases
   typedef enum logic [1:0] {PH_STRAP, PH_BANNER, PH_RUN} hup_phase_t;
   // whole state of the port
   typedef struct packed {
      hup_phase_t ph;
      logic boot, prt, fls;
      logic [3:0] bcnt;
      logic [2:0] rxs1, rxs2;
      logic [3:0] sy1, sy2; // flash, boot, slave clock, print/select
      logic dsrOld;
      logic cmd, conn, uen, stp;
      logic ract;
      logic [15:0] rcnt;
      logic [3:0] rnb;
      logic [7:0] rsh;
      logic [7:0] rdat;
      logic rval;
      logic sclkOld;
      logic [7:0] msh;
      logic fw;
   } hup_st_t;
   hup_st_t q, d;
   hup_tx_if txb();
   logic txBusy;
   logic ctsOk;
   logic rxd, cts, dsr, ssel, sclk;
   // second-stage synchroniser outputs only
   assign rxd = q.rxs2[0];
   assign cts = q.rxs2[1];
   assign dsr = q.rxs2[2];
   assign ssel = q.sy2[0];
   assign sclk = q.sy2[1];
   // two-wire treats cts as grounded; active-low cts otherwise
   assign ctsOk = twoWire ? 1'b1 : !cts;
   hup_uart_tx #(.DIV(DIV)) u_tx (
      .core_clk(core_clk),
      .rst(rst),
      .ctsOk(ctsOk),
      .tx(txb),
      .txd(txd),
      .busy(txBusy)
   );
   // banner bytes during boot, host bytes only once running
   always_comb begin
      txb.valid = 1'b0;
      txb.data = BANNER_BYTE0 + {4'h0, q.bcnt};
      if (q.ph == PH_BANNER) begin
         txb.valid = (q.bcnt != 4'(BANNER));
      end else if (q.ph == PH_RUN && q.uen) begin
         txb.valid = hostTxValid;
         txb.data = hostTxData;
      end
   end
   assign hostTxReady = (q.ph == PH_RUN) && q.uen && txb.ready;
   // rts low lets host send; held high when disabled, held low in two-wire
   assign rtsPinN = twoWire ? 1'b0 : !(q.ph == PH_RUN && q.uen && !q.rval);
   assign dtrPin = dtrLevel;
   assign rxData = q.rdat;
   assign rxValid = q.rval;
   assign factoryBoot = q.boot != STRAP_BOOT_NORMAL;
   assign flashIs18v = q.fls == STRAP_FLASH_18V;
   assign bootDone = q.ph == PH_RUN;
   assign cmdMode = q.cmd;
   assign connectable = q.conn;
   assign uartEnabled = q.uen;
   assign stopMode = q.stp;
   assign fwImageByte = q.fw;
   assign slaveSelect = (q.ph == PH_RUN) && !ssel;
   assign misoOut = q.msh[7];
   assign misoOe = (q.ph == PH_RUN) && !ssel;
   // next-state logic for the whole port
   always_comb begin
      d = q;
      d.rxs1 = {dsrPin, ctsPin, rxdPin};
      d.rxs2 = q.rxs1;
      d.sy1 = {flashStrapPin, bootStrapPin, slaveClkPin, printStrapPin};
      d.sy2 = q.sy1;
      d.dsrOld = dsr;
      d.sclkOld = sclk;
      d.fw = 1'b0;
      unique case (q.ph)
         PH_STRAP: begin
            // wait until strap levels have passed both synchroniser stages
            d.bcnt = q.bcnt + 4'h1;
            if (q.bcnt == 4'(STRAP_SYNC_CYCLES)) begin
               d.boot = q.sy2[2];
               d.prt = q.sy2[0];
               d.fls = q.sy2[3];
               d.bcnt = 4'h0;
               d.ph = (q.sy2[0] == STRAP_PRINT_ON) ? PH_BANNER : PH_RUN;
            end
         end
         PH_BANNER: begin
            // last byte must leave the line before commands are served
            if (q.bcnt != 4'(BANNER)) begin
               if (txb.ready) begin
                  d.bcnt = q.bcnt + 4'h1;
               end
            end else if (!txBusy) begin
               d.ph = PH_RUN;
            end
         end
         PH_RUN: begin
            // dsr falling edge performs the configured action
            if (q.dsrOld && !dsr) begin
               unique case (dsrAction)
                  HUP_DSR_CMD: d.cmd = 1'b1;
                  HUP_DSR_DISC: d.conn = !q.conn;
                  HUP_DSR_UART_EN: d.uen = !q.uen;
                  HUP_DSR_STOP: d.stp = !q.stp;
               endcase
            end
            // slave shifts out on rising clock edge
            if (ssel) begin
               d.msh = slaveTxByte;
            end else if (!q.sclkOld && sclk) begin
               d.msh = {q.msh[6:0], 1'b0};
            end
         end
      endcase
      // receiver: 8N1 sampled mid-bit, pulse on a good stop bit
      d.rval = 1'b0;
      if (!q.ract) begin
         if (!rxd && q.ph == PH_RUN && q.uen) begin
            d.ract = 1'b1;
            d.rcnt = 16'(DIV / 2);
            d.rnb = 4'h0;
         end
      end else if (q.rcnt == 16'h0000) begin
         d.rcnt = 16'(DIV - 1);
         d.rnb = q.rnb + 4'h1;
         if (q.rnb >= 4'h1 && q.rnb <= 4'(DATA_BITS)) begin
            d.rsh = {rxd, q.rsh[7:1]};
         end
         if (q.rnb == 4'(DATA_BITS + 1)) begin
            d.ract = 1'b0;
            if (rxd) begin
               d.rval = 1'b1;
               d.rdat = q.rsh;
               d.fw = q.cmd;
            end
         end else if (q.rnb == 4'h0 && rxd) begin
            d.ract = 1'b0;
         end
      end else begin
         d.rcnt = q.rcnt - 16'h0001;
      end
   end
   // state register; straps get defaults until captured
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         q <= '0;
         q.ph <= PH_STRAP;
         q.rxs1 <= 3'h7; // idle-high pins, no false dsr edge
         q.rxs2 <= 3'h7;
         q.boot <= STRAP_BOOT_NORMAL;
         q.prt <= STRAP_PRINT_ON;
         q.fls <= STRAP_FLASH_18V;
         q.uen <= 1'b1;
         q.conn <= 1'b1;
         q.msh <= 8'hFF;
      end else begin
         q <= d;
      end
   end
   sequence s_leaveStrap;
      q.ph == PH_STRAP ##1 q.ph != PH_STRAP;
   endsequence
   a_strap_hold: assert property (@(posedge core_clk) disable iff (rst)
      (q.ph != PH_STRAP && $past(q.ph) != PH_STRAP) |-> $stable(q.boot)) else $error("strap moved");
   a_banner_sel: assert property (@(posedge core_clk) disable iff (rst)
      s_leaveStrap |-> (q.ph == PH_BANNER) == (q.prt == STRAP_PRINT_ON)) else $error("banner select");
   a_no_host_boot: assert property (@(posedge core_clk) disable iff (rst)
      q.ph != PH_RUN |-> !hostTxReady) else $error("host tx during boot");
   a_miso_run: assert property (@(posedge core_clk) disable iff (rst)
      misoOe |-> bootDone) else $error("miso before boot");
   a_dsr_cmd: assert property (@(posedge core_clk) disable iff (rst)
      (q.ph == PH_RUN && q.dsrOld && !dsr && dsrAction == HUP_DSR_CMD) |=> cmdMode) else $error("dsr cmd");
   a_banner_drained: assert property (@(posedge core_clk) disable iff (rst)
      $rose(bootDone) |-> !txBusy) else $error("banner still sending");
   a_rts_twowire: assert property (@(posedge core_clk) disable iff (rst)
      twoWire |-> !rtsPinN) else $error("rts in two wire");
endmodule : hup_port
`default_nettype wire

// ### dv/hup_host_model.sv
// Purpose: host controller model on the far side of the serial port
// Assumes: bit time of DIV core cycles, 8N1 framing
// Notes: data line driven high from time zero and left high between frames
`timescale 1ns/1ps
`default_nettype none
module hup_host_model #(
   parameter int unsigned DIV = 4
) (
   input wire logic core_clk,
   input wire logic txd,
   input wire logic rtsPinN,
   input wire logic ctsHold,
   input wire logic twoWire,
   output logic rxdPin,
   output logic ctsPin
);
   logic [7:0] rxq[$]; // bytes seen on the device transmit line
   int frameErr = 0; // stop bits found low
   // host stalls the device by cts, grounds it when two-wire
   assign ctsPin = twoWire ? 1'b0 : ctsHold;
   initial rxdPin = 1'b1;
   // receiver: sample mid-bit, lsb first, crossed lines
   always begin : rx_proc
      logic [7:0] b;
      @(negedge txd);
      repeat (DIV / 2) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (DIV) @(posedge core_clk);
         b[i] = txd;
      end
      repeat (DIV) @(posedge core_clk);
      if (txd !== 1'b1) frameErr++;
      rxq.push_back(b);
   end
   // send one frame, only once the device lets us (bounded wait)
   task automatic sendByte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int n = 0; n < 3000 && rtsPinN !== 1'b0; n++) @(posedge core_clk);
      for (int i = 0; i < 10; i++) begin
         rxdPin <= f[i];
         repeat (DIV) @(posedge core_clk);
      end
   endtask : sendByte
endmodule : hup_host_model
`default_nettype wire

// ### dv/host_uart_port_with_boot_straps_tb.sv
// Purpose: self-checking bench for the host serial port
// Assumes: short bit time so boot banners stay brief
// Notes: flash strap held at its pulled-up level throughout
`timescale 1ns/1ps
`default_nettype none
module host_uart_port_with_boot_straps_tb;
   import hup_pkg::*;
   localparam int unsigned DV = 4; // shortened bit time
   typedef struct packed {logic boot; logic print;} hup_row_t; // strap row
   logic core_clk = 1'b0, rst = 1'b1, dsrPin = 1'b1, bootStrapPin = 1'b1, printStrapPin = 1'b1;
   logic flashStrapPin = 1'b1; // never pulled low
   logic slaveClkPin = 1'b0, twoWire = 1'b0, dtrLevel = 1'b0, hostTxValid = 1'b0, ctsHold = 1'b0;
   logic [7:0] slaveTxByte = 8'h80, hostTxData = 8'h00, gotRx = 8'h00, rxData;
   hup_dsr_act_t dsrAction = HUP_DSR_CMD;
   logic rxdPin, ctsPin, hostTxReady, txd, rtsPinN, dtrPin, rxValid, factoryBoot, flashIs18v, bootDone;
   logic cmdMode, connectable, uartEnabled, stopMode, fwImageByte, slaveSelect, misoOut, misoOe, gotFw;
   int mismatches = 0, check_count = 0;
   logic [3:0] fl = 4'h6; // expected cmd, connectable, enabled, stop
   hup_row_t rows [4] = '{'{1'b1, 1'b1}, '{1'b0, 1'b0}, '{1'b0, 1'b1}, '{1'b1, 1'b0}};
   hup_port #(.DIV(DV)) uut (.core_clk, .rst, .rxdPin, .ctsPin, .dsrPin, .bootStrapPin, .printStrapPin,
      .flashStrapPin, .slaveClkPin, .slaveTxByte, .twoWire, .dsrAction, .dtrLevel, .hostTxData,
      .hostTxValid, .hostTxReady, .txd, .rtsPinN, .dtrPin, .rxData, .rxValid, .factoryBoot, .flashIs18v,
      .bootDone, .cmdMode, .connectable, .uartEnabled, .stopMode, .fwImageByte, .slaveSelect, .misoOut,
      .misoOe);
   hup_host_model #(.DIV(DV)) host (.core_clk, .txd, .rtsPinN, .ctsHold, .twoWire, .rxdPin, .ctsPin);
   // 100 MHz core clock
   always #5 core_clk = ~core_clk;
   // keep the last received byte, since rxValid lasts one cycle
   always @(posedge core_clk) begin
      if (rxValid === 1'b1) begin
         gotRx <= rxData;
         gotFw <= fwImageByte;
      end
   end
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic ticks(input int n);
      repeat (n) @(posedge core_clk);
   endtask : ticks
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : report_and_stop
   // bounded wait for boot to finish
   task automatic waitBoot();
      for (int n = 0; bootDone !== 1'b1; n++) begin
         if (n > 3000) begin
            mismatches++;
            report_and_stop();
         end
         @(posedge core_clk);
      end
   endtask : waitBoot
   // offer a byte and hold it until ready is sampled high
   task automatic hostSend(input logic [7:0] b);
      int n;
      n = 0;
      hostTxData <= b;
      hostTxValid <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (hostTxReady !== 1'b1 && n < 3000);
      hostTxValid <= 1'b0;
      if (n >= 3000) mismatches++;
   endtask : hostSend
   // hang guard
   initial begin
      ticks(90000);
      mismatches++;
      report_and_stop();
   end
   initial begin
      // strap rows: reset, boot, compare latched levels and pin reuse
      foreach (rows[i]) begin
         host.rxq.delete();
         @(posedge core_clk);
         bootStrapPin <= rows[i].boot;
         printStrapPin <= rows[i].print;
         rst <= 1'b1;
         ticks(2);
         chk("txd in reset", 8'h01, {7'h00, txd});
         chk("misoOe in reset", 8'h00, {7'h00, misoOe});
         rst <= 1'b0;
         waitBoot();
         bootStrapPin <= ~rows[i].boot;
         ticks(4);
         chk("factoryBoot", {7'h00, ~rows[i].boot}, {7'h00, factoryBoot});
         chk("flashIs18v", 8'h01, {7'h00, flashIs18v});
         chk("banner count", rows[i].print ? 8'(BANNER_LEN) : 8'h00, 8'(host.rxq.size()));
         if (rows[i].print) chk("banner byte", BANNER_BYTE0, host.rxq[0]);
         chk("slaveSelect", {7'h00, ~rows[i].print}, {7'h00, slaveSelect});
         chk("misoOe", {7'h00, ~rows[i].print}, {7'h00, misoOe});
         if (!rows[i].print) chk("misoOut", 8'h01, {7'h00, misoOut});
      end
      // cts high holds the transmitter off, then two bytes back to back
      host.rxq.delete();
      chk("rts after boot", 8'h00, {7'h00, rtsPinN});
      ctsHold <= 1'b1;
      ticks(4);
      hostTxData <= 8'hA5;
      hostTxValid <= 1'b1;
      ticks(20);
      chk("ready under cts", 8'h00, {7'h00, hostTxReady});
      ctsHold <= 1'b0;
      hostSend(8'hA5);
      @(posedge core_clk);
      hostSend(8'h3C);
      ticks(12 * DV);
      chk("tx count", 8'h02, 8'(host.rxq.size()));
      chk("tx byte 0", 8'hA5, host.rxq[0]);
      chk("tx byte 1", 8'h3C, host.rxq[1]);
      // two-wire: cts ignored, rts held low
      twoWire <= 1'b1;
      ctsHold <= 1'b1;
      ticks(4);
      chk("rts two wire", 8'h00, {7'h00, rtsPinN});
      hostSend(8'h5A);
      ticks(12 * DV);
      chk("two wire byte", 8'h5A, host.rxq[2]);
      twoWire <= 1'b0;
      ctsHold <= 1'b0;
      host.sendByte(8'hC3);
      ticks(2 * DV);
      chk("rx byte", 8'hC3, gotRx);
      chk("fw flag off", 8'h00, {7'h00, gotFw});
      // every dsr action twice, dtr following its level
      for (int k = 0; k < 8; k++) begin
         dsrAction <= hup_dsr_act_t'(k % 4);
         dtrLevel <= 1'(k);
         dsrPin <= 1'b0;
         ticks(8);
         dsrPin <= 1'b1;
         ticks(8);
         if (k % 4 == 0) fl[3] = 1'b1;
         else fl[3 - k % 4] = ~fl[3 - k % 4];
         chk("dsr dtr", {3'h0, 1'(k), fl}, {3'h0, dtrPin, cmdMode, connectable, uartEnabled, stopMode});
      end
      host.sendByte(8'h96);
      ticks(2 * DV);
      chk("fw byte", 8'h96, gotRx);
      chk("fw flag on", 8'h01, {7'h00, gotFw});
      chk("frame errors", 8'h00, 8'(host.frameErr));
      report_and_stop();
   end
endmodule : host_uart_port_with_boot_straps_tb
`default_nettype wire
